/* File: pllcfg_pkg.sv */
/*
  pllcfg_pkg: register offsets, reset values, field positions, state codes
  and timing counts for the pll preset and reference configuration block.
  assumes a single 200 MHz clock domain and the three-wire serial port.
*/
package pllcfg_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 200; // core clock rate
	localparam int CAL_WAIT_MS = 3; // calibration finishes within this time
	// longest time as an exact count of whole cycles
	localparam int CAL_WAIT_CYC = CAL_WAIT_MS * 1000 * CLK_MHZ;
	localparam int STRAP_SETTLE_CYC = 3; // synchroniser depth plus one
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [12:0] OFS_CP = 13'h000a; // charge pump override
	localparam logic [12:0] OFS_CALCTL = 13'h000e; // vco calibration control
	localparam logic [12:0] OFS_BAND = 13'h0010; // vco band override
	localparam logic [12:0] OFS_NDIV = 13'h0011; // integer feedback divide
	localparam logic [12:0] OFS_FRAC_H = 13'h0012; // fraction [19:16]
	localparam logic [12:0] OFS_FRAC_M = 13'h0013; // fraction [15:8]
	localparam logic [12:0] OFS_FRAC_L = 13'h0014; // fraction [7:0]
	localparam logic [12:0] OFS_MOD_H = 13'h0015; // modulus [19:16]
	localparam logic [12:0] OFS_MOD_M = 13'h0016; // modulus [15:8]
	localparam logic [12:0] OFS_MOD_L = 13'h0017; // modulus [7:0]
	localparam logic [12:0] OFS_SDM = 13'h0018; // noise shaper enable
	localparam logic [12:0] OFS_STATUS = 13'h0019; // read-only status
	localparam logic [12:0] OFS_RESONATOR_PINS = 13'h001b; // resonator load tuning
	localparam logic [12:0] OFS_INOPT = 13'h001d; // input reference options
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CAL_BAND_EN_BIT = 0; // band override enable
	localparam int CAL_SPI_EN_BIT = 2; // spi calibration enable
	localparam int CAL_GO_BIT = 7; // calibrate strobe, self clearing
	localparam int RESONATOR_PINS_AUTO_BIT = 7; // 1: power-up capacitance applies
	localparam int INOPT_RESONATOR_PINS_BIT = 0; // use resonator, ignore detector
	localparam int INOPT_DBL_BIT = 2; // force input doubler
	localparam int SPI_RW_BIT = 15; // 1 = read
	localparam int SPI_CMD_BITS = 16; // instruction length
	localparam int SPI_XFER_BITS = 24; // instruction plus one data byte
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CP = 8'h00;
	localparam logic [7:0] RST_CALCTL = 8'h00;
	localparam logic [7:0] RST_BAND = 8'h00;
	localparam logic [7:0] RST_RESONATOR_PINS = 8'hbf; // auto on, field 15.75 pF
	localparam logic [7:0] RST_INOPT = 8'h00;
	localparam logic [7:0] RST_NDIV = 8'h24;
	localparam logic [19:0] RST_FRAC = 20'h00000;
	localparam logic [19:0] RST_MOD = 20'h00001;
	localparam logic [5:0] CAP_PWRUP_CODE = 6'h08; // 2 pF in 0.25 pF steps
	localparam logic [7:0] N_MIN_INT = 8'h24; // 36, shaper off
	localparam logic [7:0] N_MIN_FRAC = 8'h2f; // 47, shaper on
	// ------------------------------------------------------------
	// calibration states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CAL_WAIT = 2'b00,
		CAL_RUN = 2'b01,
		CAL_DONE = 2'b10
	} pllcfg_cal_e;
endpackage

/* File: pllcfg_sync.sv */
/*
  pllcfg_sync: two flip-flop synchroniser for a vector of pins.
  assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
module pllcfg_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// ------------------------------------------------------------
	// two stages
	// ------------------------------------------------------------
	logic [W-1:0] meta_reg; // first stage, read only by q_o
	// the first stage feeds nothing but the second
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= '0;
			q_o <= '0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

/* File: pllcfg_strap.sv */
/*
  pllcfg_strap: catches the frequency strap codes once after reset release
  and decodes the automatic doubler request.
  assumes strap inputs are already synchronised to ref_clk_i.
*/
`timescale 1ns/1ps
module pllcfg_strap
	import pllcfg_pkg::*;
#(
	parameter logic [7:0] DBL_CODE_MASK = 8'h0f
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] ref_code_i,
	input wire logic [5:0] out_code_i,
	output logic [2:0] ref_sel_o,
	output logic [5:0] out_sel_o,
	output logic strap_dbl_o,
	output logic taken_o
);
	// ------------------------------------------------------------
	// capture state
	// ------------------------------------------------------------
	logic [1:0] settle_reg, settle_next; // waits out the synchroniser
	logic [2:0] ref_next;
	logic [5:0] out_next;
	logic dbl_next;
	logic taken_next;
	// capture once, after synchronised pins are valid
	always_comb begin
		settle_next = settle_reg;
		ref_next = ref_sel_o;
		out_next = out_sel_o;
		dbl_next = strap_dbl_o;
		taken_next = taken_o;
		if (!taken_o) begin
			if (settle_reg == 2'(STRAP_SETTLE_CYC - 1)) begin
				taken_next = 1'b1;
				ref_next = ref_code_i;
				out_next = out_code_i;
				dbl_next = DBL_CODE_MASK[ref_code_i];
			end else begin
				settle_next = settle_reg + 2'h1;
			end
		end
	end
	// register the capture
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_reg <= 2'h0;
			ref_sel_o <= 3'h7;
			out_sel_o <= 6'h00;
			strap_dbl_o <= 1'b0;
			taken_o <= 1'b0;
		end else begin
			settle_reg <= settle_next;
			ref_sel_o <= ref_next;
			out_sel_o <= out_next;
			strap_dbl_o <= dbl_next;
			taken_o <= taken_next;
		end
	end
endmodule

/* File: pllcfg_top.sv */
/*
  pllcfg_top: digital configuration of a fractional-n clock upconverter:
  strap presets, serial register port, reference selection, resonator
  load tuning, vco calibration sequencing and feedback divider values.
  assumes an spi host on the three-wire port and analog logic that
  consumes the outputs and reports the band found by calibration.
*/
// Operation
// - grounded strap reads zero, open one
// - reference strap picks one of eight presets
// - some reference presets enable doubler automatically
// - option bit two forces the doubler
// - output strap picks one of 64 divider sets
// - serial writes replace strap preset dividers
// - calibrate automatically after reset
// - load capacitance 2 pF after reset
// - tuning field steps 0.25 pF
// - clearing bit seven hands capacitor to spi
// - detected reference selected, resonator off
// - option bit zero forces resonator
// - charge pump tracks divider unless overridden
// - band override selects one of 128 bands
// - integer divide limited 36 or 47 up to 255
// - fraction and modulus twenty bit values
`timescale 1ns/1ps
module pllcfg_top
	import pllcfg_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_WAIT_CYC,
	parameter logic [7:0] DBL_CODE_MASK = 8'h0f
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] ref_strap_i,
	input wire logic [5:0] out_strap_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sdio_i,
	output logic spi_sdio_o,
	output logic spi_sdio_oe_o,
	input wire logic ref_detect_i,
	input wire logic [6:0] cal_band_i,
	output logic [2:0] ref_sel_o,
	output logic [5:0] out_sel_o,
	output logic doubler_en_o,
	output logic use_ref_o,
	output logic resonator_pins_en_o,
	output logic [5:0] cap_code_o,
	output logic [7:0] cp_code_o,
	output logic cp_auto_o,
	output logic [6:0] vco_band_o,
	output logic cal_run_o,
	output logic cal_done_o,
	output logic div_spi_o,
	output logic [7:0] n_div_o,
	output logic [19:0] frac_o,
	output logic [19:0] mod_o,
	output logic fractional_noise_shaper_en_o
);
	// ------------------------------------------------------------
	// synchronisers and strap capture
	// ------------------------------------------------------------
	logic [2:0] spi_sync; // cs_n, sclk, sdio after two stages
	logic [8:0] strap_sync; // straps after two stages
	logic ref_det_sync; // reference detector level
	logic [2:0] ref_sel_w;
	logic [5:0] out_sel_w;
	logic strap_dbl;
	logic strap_taken;
	pllcfg_sync #(.W(3)) u_spi_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({spi_cs_n_i, spi_sclk_i, spi_sdio_i}),
		.q_o(spi_sync)
	);
	pllcfg_sync #(.W(10)) u_pin_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({ref_detect_i, ref_strap_i, out_strap_i}),
		.q_o({ref_det_sync, strap_sync})
	);
	pllcfg_strap #(.DBL_CODE_MASK(DBL_CODE_MASK)) u_strap (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ref_code_i(strap_sync[8:6]),
		.out_code_i(strap_sync[5:0]),
		.ref_sel_o(ref_sel_w),
		.out_sel_o(out_sel_w),
		.strap_dbl_o(strap_dbl),
		.taken_o(strap_taken)
	);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// clamp a written integer divide into its legal range
	function automatic logic [7:0] clamp_n(input logic [7:0] v, input logic fractional_noise_shaper);
		logic [7:0] lo;
		lo = fractional_noise_shaper ? N_MIN_FRAC : N_MIN_INT;
		clamp_n = (v < lo) ? lo : v;
	endfunction
	// ------------------------------------------------------------
	// serial port
	// ------------------------------------------------------------
	logic sclk_d_reg, sclk_d_next; // previous sclk for edge detect
	logic [4:0] bit_cnt_reg, bit_cnt_next; // bits taken this frame
	logic [23:0] sh_reg, sh_next; // incoming shift register
	logic [7:0] tx_reg, tx_next; // read data shifted out
	logic sdio_next, sdio_oe_next;
	logic wr_stb; // one-cycle write commit
	logic [12:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic cs_n, sclk, sdi, rise, fall;
	assign cs_n = spi_sync[2];
	assign sclk = spi_sync[1];
	assign sdi = spi_sync[0];
	assign rise = sclk & ~sclk_d_reg;
	assign fall = ~sclk & sclk_d_reg;
	// commit fires on the last shift: the frame is one bit short in sh_reg,
	// so the address sits one place lower and the last data bit is on sdi
	assign wr_addr = sh_reg[19:7];
	assign wr_data = {sh_reg[6:0], sdi};
	// shift, count and drive the data line
	always_comb begin
		sclk_d_next = sclk;
		bit_cnt_next = bit_cnt_reg;
		sh_next = sh_reg;
		tx_next = tx_reg;
		sdio_next = spi_sdio_o;
		sdio_oe_next = spi_sdio_oe_o;
		wr_stb = 1'b0;
		if (cs_n) begin
			// frame ended: release the line
			bit_cnt_next = 5'h00;
			sdio_oe_next = 1'b0;
		end else if (rise && bit_cnt_reg < 5'(SPI_XFER_BITS)) begin
			sh_next = {sh_reg[22:0], sdi};
			bit_cnt_next = bit_cnt_reg + 5'h01;
			if (bit_cnt_reg == 5'(SPI_XFER_BITS - 1) && !sh_reg[SPI_RW_BIT + 7]) begin
				wr_stb = 1'b1;
			end
			if (bit_cnt_reg == 5'(SPI_CMD_BITS - 1)) begin
				tx_next = rd_data;
			end
		end else if (fall && bit_cnt_reg >= 5'(SPI_CMD_BITS)) begin
			// read: drive msb first on falling edges
			// the read flag moves up one place with every data bit taken
			if (sh_reg[bit_cnt_reg - 5'h01] && bit_cnt_reg < 5'(SPI_XFER_BITS)) begin
				sdio_oe_next = 1'b1;
				sdio_next = tx_reg[7];
				tx_next = {tx_reg[6:0], 1'b0};
			end else begin
				sdio_oe_next = 1'b0;
			end
		end
	end
	// register the serial port
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_d_reg <= 1'b0;
			bit_cnt_reg <= 5'h00;
			sh_reg <= 24'h000000;
			tx_reg <= 8'h00;
			spi_sdio_o <= 1'b0;
			spi_sdio_oe_o <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_d_next;
			bit_cnt_reg <= bit_cnt_next;
			sh_reg <= sh_next;
			tx_reg <= tx_next;
			spi_sdio_o <= sdio_next;
			spi_sdio_oe_o <= sdio_oe_next;
		end
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] cp_reg, cp_next; // charge pump override value
	logic cp_ovr_reg, cp_ovr_next; // set once cp value is written
	logic [7:0] calctl_reg, calctl_next; // calibration control
	logic [7:0] band_reg, band_next; // band value in [7:1]
	logic [7:0] resonator_pins_reg, resonator_pins_next; // resonator load tuning
	logic [7:0] inopt_reg, inopt_next; // input options
	logic [7:0] n_reg, n_next; // integer divide
	logic [19:0] frac_reg, frac_next;
	logic [19:0] mod_reg, mod_next;
	logic sdm_reg, sdm_next; // fractional noise shaper enable
	logic div_ovr_reg, div_ovr_next; // dividers come from spi
	logic force_cal; // host-requested calibration
	pllcfg_cal_e cal_st_reg, cal_st_next;
	// read mux, sampled on the last instruction shift; address lsb is on sdi
	always_comb begin
		case ({sh_reg[11:0], sdi})
			OFS_CP: rd_data = cp_reg;
			OFS_CALCTL: rd_data = calctl_reg;
			OFS_BAND: rd_data = band_reg;
			OFS_NDIV: rd_data = n_reg;
			OFS_FRAC_H: rd_data = {4'h0, frac_reg[19:16]};
			OFS_FRAC_M: rd_data = frac_reg[15:8];
			OFS_FRAC_L: rd_data = frac_reg[7:0];
			OFS_MOD_H: rd_data = {4'h0, mod_reg[19:16]};
			OFS_MOD_M: rd_data = mod_reg[15:8];
			OFS_MOD_L: rd_data = mod_reg[7:0];
			OFS_SDM: rd_data = {7'h00, sdm_reg};
			OFS_STATUS: rd_data = {4'h0, div_ovr_reg, use_ref_o, cal_done_o, cal_run_o};
			OFS_RESONATOR_PINS: rd_data = resonator_pins_reg;
			OFS_INOPT: rd_data = inopt_reg;
			default: rd_data = 8'h00;
		endcase
	end
	// register writes
	always_comb begin
		cp_next = cp_reg;
		cp_ovr_next = cp_ovr_reg;
		calctl_next = calctl_reg;
		band_next = band_reg;
		resonator_pins_next = resonator_pins_reg;
		inopt_next = inopt_reg;
		n_next = n_reg;
		frac_next = frac_reg;
		mod_next = mod_reg;
		sdm_next = sdm_reg;
		div_ovr_next = div_ovr_reg;
		force_cal = 1'b0;
		// calibrate bit self-clears
		calctl_next[CAL_GO_BIT] = 1'b0;
		if (wr_stb) begin
			case (wr_addr)
				OFS_CP: begin
					cp_next = wr_data;
					cp_ovr_next = 1'b1;
				end
				OFS_CALCTL: begin
					calctl_next = wr_data & 8'h85;
					force_cal = wr_data[CAL_GO_BIT] & calctl_reg[CAL_SPI_EN_BIT];
				end
				OFS_BAND: band_next = {wr_data[7:1], 1'b0};
				OFS_NDIV: begin
					n_next = clamp_n(wr_data, sdm_reg);
					div_ovr_next = 1'b1;
				end
				OFS_FRAC_H: frac_next[19:16] = wr_data[3:0];
				OFS_FRAC_M: frac_next[15:8] = wr_data;
				OFS_FRAC_L: frac_next[7:0] = wr_data;
				OFS_MOD_H: mod_next[19:16] = wr_data[3:0];
				OFS_MOD_M: mod_next[15:8] = wr_data;
				OFS_MOD_L: mod_next[7:0] = wr_data;
				OFS_SDM: begin
					sdm_next = wr_data[0];
					n_next = clamp_n(n_reg, wr_data[0]);
					div_ovr_next = 1'b1;
				end
				OFS_RESONATOR_PINS: resonator_pins_next = wr_data & 8'hbf;
				OFS_INOPT: inopt_next = wr_data & 8'h05;
				default: ;
			endcase
			if (wr_addr >= OFS_FRAC_H && wr_addr <= OFS_MOD_L) begin
				div_ovr_next = 1'b1;
			end
		end
	end
	// register the register file
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cp_reg <= RST_CP;
			cp_ovr_reg <= 1'b0;
			calctl_reg <= RST_CALCTL;
			band_reg <= RST_BAND;
			resonator_pins_reg <= RST_RESONATOR_PINS;
			inopt_reg <= RST_INOPT;
			n_reg <= RST_NDIV;
			frac_reg <= RST_FRAC;
			mod_reg <= RST_MOD;
			sdm_reg <= 1'b0;
			div_ovr_reg <= 1'b0;
		end else begin
			cp_reg <= cp_next;
			cp_ovr_reg <= cp_ovr_next;
			calctl_reg <= calctl_next;
			band_reg <= band_next;
			resonator_pins_reg <= resonator_pins_next;
			inopt_reg <= inopt_next;
			n_reg <= n_next;
			frac_reg <= frac_next;
			mod_reg <= mod_next;
			sdm_reg <= sdm_next;
			div_ovr_reg <= div_ovr_next;
		end
	end
	// ------------------------------------------------------------
	// vco calibration sequencer
	// ------------------------------------------------------------
	logic [$clog2(CAL_CYCLES+1)-1:0] cal_cnt_reg, cal_cnt_next;
	logic [6:0] auto_band_reg, auto_band_next; // band found by calibration
	logic ref_ok; // a usable reference is present
	assign ref_ok = ref_det_sync | inopt_reg[INOPT_RESONATOR_PINS_BIT];
	// wait for reference and straps, run, finish
	always_comb begin
		cal_st_next = cal_st_reg;
		cal_cnt_next = cal_cnt_reg;
		auto_band_next = auto_band_reg;
		case (cal_st_reg)
			CAL_WAIT: begin
				if (ref_ok && strap_taken) begin
					cal_st_next = CAL_RUN;
					cal_cnt_next = '0;
				end
			end
			CAL_RUN: begin
				if (cal_cnt_reg == ($bits(cal_cnt_reg))'(CAL_CYCLES - 1)) begin
					cal_st_next = CAL_DONE;
					auto_band_next = cal_band_i;
				end else begin
					cal_cnt_next = cal_cnt_reg + 1'b1;
				end
			end
			CAL_DONE: ;
			default: cal_st_next = CAL_WAIT;
		endcase
		if (force_cal) begin
			cal_st_next = CAL_WAIT;
		end
	end
	// register the sequencer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_st_reg <= CAL_WAIT;
			cal_cnt_reg <= '0;
			auto_band_reg <= 7'h00;
		end else begin
			cal_st_reg <= cal_st_next;
			cal_cnt_reg <= cal_cnt_next;
			auto_band_reg <= auto_band_next;
		end
	end
	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_sel_o <= 3'h0;
			out_sel_o <= 6'h00;
			doubler_en_o <= 1'b0;
			use_ref_o <= 1'b0;
			resonator_pins_en_o <= 1'b1;
			cap_code_o <= CAP_PWRUP_CODE;
			cp_code_o <= RST_NDIV;
			cp_auto_o <= 1'b1;
			vco_band_o <= 7'h00;
			cal_run_o <= 1'b0;
			cal_done_o <= 1'b0;
			div_spi_o <= 1'b0;
			n_div_o <= RST_NDIV;
			frac_o <= RST_FRAC;
			mod_o <= RST_MOD;
			fractional_noise_shaper_en_o <= 1'b0;
		end else begin
			ref_sel_o <= ref_sel_w;
			out_sel_o <= out_sel_w;
			doubler_en_o <= strap_dbl | inopt_reg[INOPT_DBL_BIT];
			use_ref_o <= ref_det_sync & ~inopt_reg[INOPT_RESONATOR_PINS_BIT];
			resonator_pins_en_o <= ~(ref_det_sync & ~inopt_reg[INOPT_RESONATOR_PINS_BIT]);
			cap_code_o <= resonator_pins_reg[RESONATOR_PINS_AUTO_BIT] ? CAP_PWRUP_CODE : resonator_pins_reg[5:0];
			cp_code_o <= cp_ovr_reg ? cp_reg : n_reg;
			cp_auto_o <= ~cp_ovr_reg;
			vco_band_o <= calctl_reg[CAL_BAND_EN_BIT] ? band_reg[7:1] : auto_band_reg;
			cal_run_o <= (cal_st_reg == CAL_RUN);
			cal_done_o <= (cal_st_reg == CAL_DONE);
			div_spi_o <= div_ovr_reg;
			n_div_o <= n_reg;
			frac_o <= frac_reg;
			mod_o <= mod_reg;
			fractional_noise_shaper_en_o <= sdm_reg;
		end
	end
endmodule

/* File: pllcfg_host.sv */
/*
  pllcfg_host: serial host model, 24-bit frames, mode 0, msb first.
  assumes the bench resolves the shared data line and hands it back.
*/
`timescale 1ns/1ps
module pllcfg_host (
	input wire logic ref_clk_i,
	input wire logic sdio_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdio_o
);
	// idle: clock low, select high
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdio_o = 1'b0;
	end
	// ------------------------------------------------------------
	// one frame: read flag, two zero bits, address, data
	// ------------------------------------------------------------
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [23:0] f;
		f = {rd, 2'b00, a, d};
		q = 8'h00;
		@(posedge ref_clk_i);
		cs_n_o <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			repeat (5) @(posedge ref_clk_i);
			// read data phase: toggle so a released line never looks stable
			sdio_o <= (rd && i < 8) ? ~sdio_o : f[i];
			repeat (5) @(posedge ref_clk_i);
			sclk_o <= 1'b1;
			repeat (5) @(posedge ref_clk_i);
			if (i < 8) begin
				q[i] = sdio_i;
			end
			sclk_o <= 1'b0;
		end
		repeat (5) @(posedge ref_clk_i);
		cs_n_o <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
	endtask
endmodule

/* File: pllcfg_top_chk.sv */
/*
  pllcfg_top_chk: port-level timing checks of pllcfg_top.
  assumes one clock domain; bound to every pllcfg_top below.
*/
`timescale 1ns/1ps
module pllcfg_top_chk
	import pllcfg_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_WAIT_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ref_detect_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sdio_oe_o,
	input wire logic use_ref_o,
	input wire logic resonator_pins_en_o,
	input wire logic [5:0] cap_code_o,
	input wire logic [7:0] cp_code_o,
	input wire logic cp_auto_o,
	input wire logic [7:0] n_div_o,
	input wire logic fractional_noise_shaper_en_o,
	input wire logic cal_run_o,
	input wire logic cal_done_o,
	input wire logic [2:0] ref_sel_o,
	input wire logic [5:0] out_sel_o
);
	logic [3:0] up_reg; // edges since reset, saturating
	logic [31:0] run_reg; // cycles spent in a calibration run
	// helper counters
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_reg <= 4'h0;
			run_reg <= 32'h0;
		end else begin
			up_reg <= (up_reg == 4'hf) ? up_reg : up_reg + 4'h1;
			run_reg <= cal_run_o ? run_reg + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_res; resonator_pins_en_o == !use_ref_o; endproperty
	a_res: assert property (p_res) else $error("resonator not opposite");
	property p_noref; !ref_detect_i [*5] |-> !use_ref_o; endproperty
	a_noref: assert property (p_noref) else $error("ref used without clock");
	property p_cp; cp_auto_o |-> cp_code_o == n_div_o; endproperty
	a_cp: assert property (p_cp) else $error("pump not tracking divider");
	property p_nmin; n_div_o >= N_MIN_INT; endproperty
	a_nmin: assert property (p_nmin) else $error("divider below 36");
	property p_nfrac;
		fractional_noise_shaper_en_o && $past(fractional_noise_shaper_en_o)
			|-> n_div_o >= N_MIN_FRAC;
	endproperty
	a_nfrac: assert property (p_nfrac) else $error("divider below 47");
	property p_done; $rose(cal_done_o) |-> $past(cal_run_o) && !cal_run_o; endproperty
	a_done: assert property (p_done) else $error("done without run");
	property p_runlen;
		$fell(cal_run_o) |-> run_reg inside {[CAL_CYCLES - 1:CAL_CYCLES + 1]};
	endproperty
	a_runlen: assert property (p_runlen) else $error("run length wrong");
	property p_cap; $rose(rst_n_i) |-> cap_code_o == CAP_PWRUP_CODE; endproperty
	a_cap: assert property (p_cap) else $error("cap code not 2 pF");
	property p_hold; up_reg > 4'h6 |-> $stable(ref_sel_o) && $stable(out_sel_o); endproperty
	a_hold: assert property (p_hold) else $error("strap codes changed");
	property p_oe; spi_cs_n_i [*6] |-> !spi_sdio_oe_o; endproperty
	a_oe: assert property (p_oe) else $error("data driven while idle");
	c_done: cover property ($rose(cal_done_o));
	c_cpov: cover property ($fell(cp_auto_o));
	c_frac: cover property ($rose(fractional_noise_shaper_en_o));
endmodule
bind pllcfg_top pllcfg_top_chk #(.CAL_CYCLES(CAL_CYCLES)) u_pllcfg_top_chk (.*);

/* File: pllcfg_top_tb.sv */
/*
  pllcfg_top_tb: straps, serial registers and calibration of pllcfg_top.
  assumes pllcfg_host as serial host and the bound checker.
*/
`timescale 1ns/1ps
module pllcfg_top_tb;
	import pllcfg_pkg::*;
	logic clk, rst_n, sclk, cs_n, hsd, dsd, doe, det;
	wire logic line = doe ? dsd : hsd; // shared data line
	logic [2:0] rs, rsel;
	logic [5:0] os, osel, cap;
	logic dbl, uref, res, cpa, run, done, dspi, fen;
	logic [7:0] cp, nd, q;
	logic [6:0] cb, band;
	logic [19:0] frac, modv;
	int errors, n_compared;
	pllcfg_top #(.CAL_CYCLES(60)) u_pllcfg_top (
		.ref_clk_i(clk), .rst_n_i(rst_n), .ref_strap_i(rs), .out_strap_i(os),
		.spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdio_i(line),
		.spi_sdio_o(dsd), .spi_sdio_oe_o(doe), .ref_detect_i(det), .cal_band_i(cb),
		.ref_sel_o(rsel), .out_sel_o(osel), .doubler_en_o(dbl), .use_ref_o(uref),
		.resonator_pins_en_o(res), .cap_code_o(cap), .cp_code_o(cp),
		.cp_auto_o(cpa), .vco_band_o(band), .cal_run_o(run), .cal_done_o(done),
		.div_spi_o(dspi), .n_div_o(nd), .frac_o(frac), .mod_o(modv),
		.fractional_noise_shaper_en_o(fen)
	);
	pllcfg_host u_pllcfg_host (
		.ref_clk_i(clk), .sdio_i(line), .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(hsd)
	);
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [12:0] a, input logic [7:0] d);
		u_pllcfg_host.xfer(1'b0, a, d, q);
		tick(1);
	endtask
	task rd(input logic [12:0] a, input logic [7:0] e, input string s);
		u_pllcfg_host.xfer(1'b1, a, 8'h00, q);
		chk(s, e, q);
	endtask
	task waitcal;
		for (int i = 0; i < 400 && done !== 1'b1; i++) tick(1);
	endtask
	task end_sim;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset(input logic [2:0] v);
		@(posedge clk);
		rs <= v;
		os <= 6'h2a;
		rst_n <= 1'b0;
		tick(8);
		@(posedge clk);
		rst_n <= 1'b1;
		tick(6);
		chk("ref_sel", v, rsel);
		chk("out_sel", 6'h2a, osel);
		chk("doubler", v < 3'h4, dbl);
		chk("cap", 6'h08, cap);
		chk("cp_auto", 1'b1, cpa);
		chk("use_ref", 1'b1, uref);
		@(posedge clk);
		rs <= ~v;
		os <= 6'h15;
		tick(6);
		chk("ref_held", v, rsel);
		waitcal;
		chk("cal_done", 1'b1, done);
		chk("band", 7'h33, band);
		$display("test reset done");
	endtask
	task t_regs;
		wr(OFS_INOPT, 8'h04);
		chk("dbl_forced", 1'b1, dbl);
		wr(OFS_INOPT, 8'h05);
		chk("res_forced", 1'b1, res);
		rd(OFS_INOPT, 8'h05, "inopt");
		rd(13'h0030, 8'h00, "unmapped");
		wr(OFS_INOPT, 8'h00);
		@(posedge clk);
		det <= 1'b0;
		tick(8);
		chk("no_ref", 1'b0, uref);
		@(posedge clk);
		det <= 1'b1;
		rd(OFS_RESONATOR_PINS, RST_RESONATOR_PINS, "resonator_pins_rst");
		wr(OFS_RESONATOR_PINS, 8'h3f);
		chk("cap_spi", 6'h3f, cap);
		wr(OFS_RESONATOR_PINS, 8'h14);
		chk("cap_step", 6'h14, cap);
		wr(OFS_CP, 8'h55);
		chk("cp_over", 9'h055, {cpa, cp});
		wr(OFS_CALCTL, 8'h01);
		wr(OFS_BAND, 8'h54);
		chk("band_over", 7'h2a, band);
		$display("test registers done");
	endtask
	task t_cal;
		wr(OFS_CALCTL, 8'h80);
		chk("cal_refused", 2'b10, {done, run});
		wr(OFS_CALCTL, 8'h05);
		wr(OFS_CALCTL, 8'h85);
		chk("cal_forced", 1'b1, run);
		waitcal;
		chk("cal_again", 1'b1, done);
		rd(OFS_CALCTL, 8'h05, "cal_selfclr");
		$display("test calibration done");
	endtask
	task t_div;
		wr(OFS_NDIV, 8'h10);
		chk("n_clamp", 9'h124, {dspi, nd});
		wr(OFS_SDM, 8'h01);
		chk("n_frac", 9'h12f, {fen, nd});
		wr(OFS_NDIV, 8'hff);
		chk("n_max", 8'hff, nd);
		wr(OFS_FRAC_H, 8'h0a);
		wr(OFS_FRAC_M, 8'hbc);
		wr(OFS_FRAC_L, 8'hde);
		chk("frac", 20'habcde, frac);
		wr(OFS_MOD_L, 8'h03);
		chk("mod", 20'h00003, modv);
		$display("test dividers done");
	endtask
	// main sequence; host waits for calibration before writes
	initial begin
		errors = 0;
		n_compared = 0;
		rst_n = 1'b0;
		rs = 3'h0;
		os = 6'h00;
		det = 1'b1;
		cb = 7'h33;
		t_reset(3'h2);
		t_reset(3'h5);
		t_regs();
		t_cal();
		t_div();
		end_sim();
	end
	// watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		end_sim();
	end
endmodule
